// ===== ltc_params.svh
// offsets, field positions and reset values of the two tuning words
`ifndef LTC_PARAMS_SVH
`define LTC_PARAMS_SVH

// ----------------------------------------------------------------
// bus map
// ----------------------------------------------------------------
`define LTC_ADDR_W      12
`define LTC_ATC_LO_OFS  12'h000
`define LTC_ATC_HI_OFS  12'h004
`define LTC_BDC_LO_OFS  12'h008
`define LTC_BDC_HI_OFS  12'h00C

// ----------------------------------------------------------------
// word layout
// ----------------------------------------------------------------
`define LTC_WORD_W      48
`define LTC_NIB_W       4
`define LTC_GAIN_W      8
`define LTC_TRI_W       3
`define LTC_ATC_RST     48'h0380_0000_0666
`define LTC_ATC_RW      48'h078F_FFFF_FFFF
`define LTC_BDC_RST     48'h003B_7F7F_7F00
`define LTC_BDC_RW      48'hFFFF_FFFF_FF00

// first word fields
`define LTC_GPD_LSB     4
`define LTC_BPD_LSB     8
`define LTC_RDC_LSB     12
`define LTC_GDC_LSB     16
`define LTC_BDCP_LSB    20
`define LTC_RLG_LSB     24
`define LTC_GLG_LSB     28
`define LTC_BLG_LSB     32
`define LTC_RNS_BIT     39
`define LTC_GNS_BIT     40
`define LTC_BNS_BIT     41
`define LTC_SUBP_BIT    42

// second word fields
`define LTC_RCG_LSB     8
`define LTC_GCG_LSB     16
`define LTC_BCG_LSB     24
`define LTC_GBR_LSB     32
`define LTC_SRM_LSB     35
`define LTC_RTH_LSB     39
`define LTC_GTH_LSB     42
`define LTC_BTH_LSB     45

`endif

// ===== ltc_pkg.sv
// types and shared decoding of the tuning register bank
`default_nettype none
`include "ltc_params.svh"

package ltc_pkg;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        LTC_TGT_NONE,
        LTC_TGT_ATC_LO,
        LTC_TGT_ATC_HI,
        LTC_TGT_BDC_LO,
        LTC_TGT_BDC_HI
    } ltc_target_t;

    typedef struct packed {
        logic [`LTC_WORD_W-1:0] word;
    } ltc_word_state_t;

    typedef struct packed {
        logic [31:0] rdata;
        logic        slverr;
    } ltc_bus_state_t;

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic ltc_target_t ltc_decode(logic [`LTC_ADDR_W-1:0] addr);
        ltc_target_t t;
        t = LTC_TGT_NONE;
        if (addr == `LTC_ATC_LO_OFS)
            t = LTC_TGT_ATC_LO;
        else if (addr == `LTC_ATC_HI_OFS)
            t = LTC_TGT_ATC_HI;
        else if (addr == `LTC_BDC_LO_OFS)
            t = LTC_TGT_BDC_LO;
        else if (addr == `LTC_BDC_HI_OFS)
            t = LTC_TGT_BDC_HI;
        return t;
    endfunction

    // byte strobes to bit mask; the upper half uses lanes 0 and 1 only
    function automatic logic [`LTC_WORD_W-1:0] ltc_lane_mask(logic [3:0] strb, logic hi);
        logic [`LTC_WORD_W-1:0] m;
        m = 48'h0000_0000_0000;
        for (int b = 0; b < 4; b++)
        begin
            if (!hi)
                m[8*b +: 8] = {8{strb[b]}};
            else if (b < 2)
                m[32+8*b +: 8] = {8{strb[b]}};
        end
        return m;
    endfunction

endpackage

`default_nettype wire

// ===== ltc_cfg_if.sv
// write path from the bus decoder to the tuning words
`timescale 1ns/10ps
`default_nettype none

interface ltc_cfg_if;
    logic [1:0]  wr_en;
    logic        hi;
    logic [31:0] wdata;
    logic [3:0]  strb;

    modport ctl  (output wr_en, hi, wdata, strb);
    modport word (input  wr_en, hi, wdata, strb);
endinterface

`default_nettype wire

// ===== ltc_apb_decode.sv
// APB address decode and write strobes for the tuning words
`timescale 1ns/10ps
`default_nettype none
`include "ltc_params.svh"

module ltc_apb_decode
(
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`LTC_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    ltc_cfg_if.ctl                      bus,
    output ltc_pkg::ltc_target_t        target
);

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    assign target = ltc_pkg::ltc_decode(paddr);

    always_comb
    begin
        bus.wr_en = 2'h0;
        bus.hi    = 1'h0;
        bus.wdata = pwdata;
        bus.strb  = pstrb;
        unique case (target)
            ltc_pkg::LTC_TGT_ATC_LO:
            begin
                bus.wr_en[0] = psel & penable & pwrite;
            end
            ltc_pkg::LTC_TGT_ATC_HI:
            begin
                bus.wr_en[0] = psel & penable & pwrite;
                bus.hi       = 1'h1;
            end
            ltc_pkg::LTC_TGT_BDC_LO:
            begin
                bus.wr_en[1] = psel & penable & pwrite;
            end
            ltc_pkg::LTC_TGT_BDC_HI:
            begin
                bus.wr_en[1] = psel & penable & pwrite;
                bus.hi       = 1'h1;
            end
            ltc_pkg::LTC_TGT_NONE:
            begin
                bus.wr_en = 2'h0;
            end
        endcase
    end

endmodule

`default_nettype wire

// ===== ltc_word_reg.sv
// one 48-bit tuning word with writable-bit mask and fixed reserved bits
`timescale 1ns/10ps
`default_nettype none
`include "ltc_params.svh"

module ltc_word_reg
#(
    parameter int                     IDX       = 0,
    parameter logic [`LTC_WORD_W-1:0] RESET_VAL = 48'h0000_0000_0000,
    parameter logic [`LTC_WORD_W-1:0] RW_MASK   = 48'h0000_0000_0000
)
(
    input  wire logic                   clk,
    input  wire logic                   rst,
    ltc_cfg_if.word                     bus,
    output logic [`LTC_WORD_W-1:0]      word
);

    ltc_pkg::ltc_word_state_t state;
    ltc_pkg::ltc_word_state_t next_state;
    logic [`LTC_WORD_W-1:0]   wmask;
    logic [`LTC_WORD_W-1:0]   wdata48;

    // ----------------------------------------------------------------
    // update
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        wmask   = ltc_pkg::ltc_lane_mask(bus.strb, bus.hi) & RW_MASK;
        wdata48 = bus.hi ? {bus.wdata[15:0], 32'h0000_0000} : {16'h0000, bus.wdata};
        if (bus.wr_en[IDX])
            next_state.word = (state.word & ~wmask) | (wdata48 & wmask);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            state.word <= RESET_VAL;
        else
            state <= next_state;
    end

    assign word = state.word;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    reserved_fixed_a: assert property (
        (word & ~RW_MASK) == (RESET_VAL & ~RW_MASK))
        else $error("reserved bits changed");

    reset_value_a: assert property (
        $fell(rst) |-> word == RESET_VAL)
        else $error("word not at reset value after reset");

    no_write_hold_a: assert property (
        !bus.wr_en[IDX] |=> $stable(word))
        else $error("word changed without a write");

endmodule

`default_nettype wire

// ===== ltc_config_regs.sv
// APB slave holding the analog tuning and brightness/detect words
`timescale 1ns/10ps
`default_nettype none
`include "ltc_params.svh"

module ltc_config_regs
(
    input  wire logic                   REF_CLK,
    input  wire logic                   RST,
    input  wire logic                   PSEL,
    input  wire logic                   PENABLE,
    input  wire logic                   PWRITE,
    input  wire logic [`LTC_ADDR_W-1:0] PADDR,
    input  wire logic [31:0]            PWDATA,
    input  wire logic [3:0]             PSTRB,
    output logic [31:0]                 PRDATA,
    output logic                        PREADY,
    output logic                        PSLVERR,
    output logic [`LTC_NIB_W-1:0]       GREEN_PREDISCHARGE_LEVEL,
    output logic [`LTC_NIB_W-1:0]       BLUE_PREDISCHARGE_LEVEL,
    output logic [`LTC_NIB_W-1:0]       RED_DECOUPLING_LEVEL,
    output logic [`LTC_NIB_W-1:0]       GREEN_DECOUPLING_LEVEL,
    output logic [`LTC_NIB_W-1:0]       BLUE_DECOUPLING_LEVEL,
    output logic [`LTC_NIB_W-1:0]       RED_LOWGRAY_COMPENSATION,
    output logic [`LTC_NIB_W-1:0]       GREEN_LOWGRAY_COMPENSATION,
    output logic [`LTC_NIB_W-1:0]       BLUE_LOWGRAY_COMPENSATION,
    output logic                        RED_GROUP_NOISE_SELECT,
    output logic                        GREEN_GROUP_NOISE_SELECT,
    output logic                        BLUE_GROUP_NOISE_SELECT,
    output logic                        SUBPERIOD_CAP_ENABLE,
    output logic [`LTC_GAIN_W-1:0]      RED_COLOUR_GAIN,
    output logic [`LTC_GAIN_W-1:0]      GREEN_COLOUR_GAIN,
    output logic [`LTC_GAIN_W-1:0]      BLUE_COLOUR_GAIN,
    output logic [`LTC_TRI_W-1:0]       GLOBAL_BRIGHTNESS,
    output logic [`LTC_NIB_W-1:0]       SHORT_REMOVAL_LEVEL,
    output logic [`LTC_TRI_W-1:0]       RED_SHORT_THRESHOLD,
    output logic [`LTC_TRI_W-1:0]       GREEN_SHORT_THRESHOLD,
    output logic [`LTC_TRI_W-1:0]       BLUE_SHORT_THRESHOLD
);

    localparam logic [`LTC_WORD_W-1:0] RST_V [2] = '{`LTC_ATC_RST, `LTC_BDC_RST};
    localparam logic [`LTC_WORD_W-1:0] RW_M  [2] = '{`LTC_ATC_RW, `LTC_BDC_RW};

    ltc_cfg_if                cfg ();
    ltc_pkg::ltc_target_t     target;
    logic [`LTC_WORD_W-1:0]   words [2];
    logic [`LTC_WORD_W-1:0]   atc;
    logic [`LTC_WORD_W-1:0]   bdc;
    ltc_pkg::ltc_bus_state_t  state;
    ltc_pkg::ltc_bus_state_t  next_state;

    // ----------------------------------------------------------------
    // decode and storage
    // ----------------------------------------------------------------
    ltc_apb_decode u_decode
    (
        .psel    (PSEL),
        .penable (PENABLE),
        .pwrite  (PWRITE),
        .paddr   (PADDR),
        .pwdata  (PWDATA),
        .pstrb   (PSTRB),
        .bus     (cfg.ctl),
        .target  (target)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_word
            ltc_word_reg
            #(
                .IDX       (gi),
                .RESET_VAL (RST_V[gi]),
                .RW_MASK   (RW_M[gi])
            )
            u_word
            (
                .clk  (REF_CLK),
                .rst  (RST),
                .bus  (cfg.word),
                .word (words[gi])
            );
        end
    endgenerate

    assign atc = words[0];
    assign bdc = words[1];

    // ----------------------------------------------------------------
    // read data, captured in the setup cycle
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        if (PSEL && !PENABLE)
        begin
            next_state.slverr = 1'h0;
            unique case (target)
                ltc_pkg::LTC_TGT_ATC_LO:
                    next_state.rdata = atc[31:0];
                ltc_pkg::LTC_TGT_ATC_HI:
                    next_state.rdata = {16'h0000, atc[47:32]};
                ltc_pkg::LTC_TGT_BDC_LO:
                    next_state.rdata = bdc[31:0];
                ltc_pkg::LTC_TGT_BDC_HI:
                    next_state.rdata = {16'h0000, bdc[47:32]};
                ltc_pkg::LTC_TGT_NONE:
                begin
                    next_state.rdata  = 32'h0000_0000;
                    next_state.slverr = 1'h1;
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            state.rdata  <= 32'h0000_0000;
            state.slverr <= 1'h0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign PREADY  = PSEL & PENABLE;
    assign PSLVERR = PSEL & PENABLE & state.slverr;
    assign PRDATA  = state.rdata;

    // ----------------------------------------------------------------
    // field outputs
    // ----------------------------------------------------------------
    // green pre-discharge out
    assign GREEN_PREDISCHARGE_LEVEL   = atc[`LTC_GPD_LSB +: `LTC_NIB_W];
    assign BLUE_PREDISCHARGE_LEVEL    = atc[`LTC_BPD_LSB +: `LTC_NIB_W];
    assign RED_DECOUPLING_LEVEL       = atc[`LTC_RDC_LSB +: `LTC_NIB_W];
    assign GREEN_DECOUPLING_LEVEL     = atc[`LTC_GDC_LSB +: `LTC_NIB_W];
    assign BLUE_DECOUPLING_LEVEL      = atc[`LTC_BDCP_LSB +: `LTC_NIB_W];
    assign RED_LOWGRAY_COMPENSATION   = atc[`LTC_RLG_LSB +: `LTC_NIB_W];
    assign GREEN_LOWGRAY_COMPENSATION = atc[`LTC_GLG_LSB +: `LTC_NIB_W];
    assign BLUE_LOWGRAY_COMPENSATION  = atc[`LTC_BLG_LSB +: `LTC_NIB_W];
    assign RED_GROUP_NOISE_SELECT     = atc[`LTC_RNS_BIT];
    assign GREEN_GROUP_NOISE_SELECT   = atc[`LTC_GNS_BIT];
    assign BLUE_GROUP_NOISE_SELECT    = atc[`LTC_BNS_BIT];
    assign SUBPERIOD_CAP_ENABLE       = atc[`LTC_SUBP_BIT];
    assign RED_COLOUR_GAIN            = bdc[`LTC_RCG_LSB +: `LTC_GAIN_W];
    assign GREEN_COLOUR_GAIN          = bdc[`LTC_GCG_LSB +: `LTC_GAIN_W];
    assign BLUE_COLOUR_GAIN           = bdc[`LTC_BCG_LSB +: `LTC_GAIN_W];
    assign GLOBAL_BRIGHTNESS          = bdc[`LTC_GBR_LSB +: `LTC_TRI_W];
    assign SHORT_REMOVAL_LEVEL        = bdc[`LTC_SRM_LSB +: `LTC_NIB_W];
    assign RED_SHORT_THRESHOLD        = bdc[`LTC_RTH_LSB +: `LTC_TRI_W];
    assign GREEN_SHORT_THRESHOLD      = bdc[`LTC_GTH_LSB +: `LTC_TRI_W];
    assign BLUE_SHORT_THRESHOLD       = bdc[`LTC_BTH_LSB +: `LTC_TRI_W];

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);

    sequence atc_lo_wr;
        PSEL && PENABLE && PWRITE && PADDR == `LTC_ATC_LO_OFS && PSTRB == 4'hF;
    endsequence

    sequence atc_hi_wr;
        PSEL && PENABLE && PWRITE && PADDR == `LTC_ATC_HI_OFS && PSTRB == 4'hF;
    endsequence

    sequence bdc_lo_wr;
        PSEL && PENABLE && PWRITE && PADDR == `LTC_BDC_LO_OFS && PSTRB == 4'hF;
    endsequence

    sequence bdc_hi_wr;
        PSEL && PENABLE && PWRITE && PADDR == `LTC_BDC_HI_OFS && PSTRB == 4'hF;
    endsequence

    sequence setup_rd;
        PSEL && !PENABLE && !PWRITE;
    endsequence

    green_pd_write_a: assert property (
        atc_lo_wr |=> GREEN_PREDISCHARGE_LEVEL == $past(PWDATA[7:4]))
        else $error("green pre-discharge not written");

    blue_pd_write_a: assert property (
        atc_lo_wr |=> BLUE_PREDISCHARGE_LEVEL == $past(PWDATA[11:8]))
        else $error("blue pre-discharge not written");

    decouple_write_a: assert property (
        atc_lo_wr |=> {BLUE_DECOUPLING_LEVEL, GREEN_DECOUPLING_LEVEL,
                       RED_DECOUPLING_LEVEL} == $past(PWDATA[23:12]))
        else $error("decoupling levels not written");

    lowgray_write_a: assert property (
        atc_hi_wr |=> BLUE_LOWGRAY_COMPENSATION == $past(PWDATA[3:0])
                      && $stable(RED_LOWGRAY_COMPENSATION))
        else $error("low-gray compensation write wrong");

    noise_sel_a: assert property (
        atc_hi_wr |=> {BLUE_GROUP_NOISE_SELECT, GREEN_GROUP_NOISE_SELECT,
                       RED_GROUP_NOISE_SELECT} == $past(PWDATA[9:7]))
        else $error("noise selects not written");

    subp_cap_a: assert property (
        atc_hi_wr |=> SUBPERIOD_CAP_ENABLE == $past(PWDATA[10]))
        else $error("subperiod cap not written");

    gain_write_a: assert property (
        bdc_lo_wr |=> {BLUE_COLOUR_GAIN, GREEN_COLOUR_GAIN, RED_COLOUR_GAIN}
                      == $past(PWDATA[31:8]))
        else $error("colour gains not written");

    glob_bright_a: assert property (
        bdc_hi_wr |=> GLOBAL_BRIGHTNESS == $past(PWDATA[2:0]))
        else $error("global brightness not written");

    short_rm_a: assert property (
        bdc_hi_wr |=> SHORT_REMOVAL_LEVEL == $past(PWDATA[6:3]))
        else $error("short removal level not written");

    red_thresh_a: assert property (
        bdc_hi_wr |=> RED_SHORT_THRESHOLD == $past(PWDATA[9:7]))
        else $error("red threshold not written");

    gb_thresh_a: assert property (
        bdc_hi_wr |=> {BLUE_SHORT_THRESHOLD, GREEN_SHORT_THRESHOLD}
                      == $past(PWDATA[15:10]))
        else $error("green or blue threshold not written");

    reserved_read_a: assert property (
        setup_rd ##1 (PSEL && PENABLE && PADDR == `LTC_BDC_LO_OFS)
        |-> PRDATA[7:0] == 8'h00)
        else $error("reserved low byte not zero");

    reset_fields_a: assert property (
        $fell(RST) |-> GLOBAL_BRIGHTNESS == 3'h3 && SHORT_REMOVAL_LEVEL == 4'h7
                       && RED_COLOUR_GAIN == 8'h7F && GREEN_PREDISCHARGE_LEVEL == 4'h6)
        else $error("fields not at reset values");

    unmapped_err_a: assert property (
        (PSEL && !PENABLE && target == ltc_pkg::LTC_TGT_NONE) ##1 (PSEL && PENABLE)
        |-> PSLVERR && PREADY)
        else $error("unmapped access not answered with error");

endmodule

`default_nettype wire

// ===== ltc_config_regs_tb.sv
// self-checking bench for the tuning register bank
`timescale 1ns/10ps
`default_nettype none
`include "ltc_params.svh"
`define CHK(g, e) \
    begin \
        cmp_count++; \
        if ((g) !== (e)) \
        begin \
            bad_count++; \
            $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); \
        end \
    end

module ltc_config_regs_tb;
    // ----------------------------------------------------------------
    // expected layout
    // ----------------------------------------------------------------
    localparam logic [47:0] RST0 = 48'h0380_0000_0666;
    localparam logic [47:0] RW0  = 48'h078F_FFFF_FFFF;
    localparam logic [47:0] RST1 = 48'h003B_7F7F_7F00;
    localparam logic [47:0] RW1  = 48'hFFFF_FFFF_FF00;

    logic        ref_clk = 1'b0;
    logic        rst     = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [3:0]  pstrb   = 4'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  gpd, bpd, rdc, gdc, bdc, rlg, glg, blg, srm;
    logic        rns, gns, bns, subp;
    logic [7:0]  rcg, gcg, bcg;
    logic [2:0]  gbr, rth, gth, bth;
    int          bad_count = 0;
    int          cmp_count = 0;
    logic [47:0] e0, e1;
    logic [31:0] rd;
    logic        err;
    logic [11:0] paddr_tab [4] = '{12'h010, 12'h002, 12'hFFC, 12'h00E};

    always #4 ref_clk = ~ref_clk;

    ltc_config_regs u_dut
    (
        .REF_CLK                    (ref_clk),
        .RST                        (rst),
        .PSEL                       (psel),
        .PENABLE                    (penable),
        .PWRITE                     (pwrite),
        .PADDR                      (paddr),
        .PWDATA                     (pwdata),
        .PSTRB                      (pstrb),
        .PRDATA                     (prdata),
        .PREADY                     (pready),
        .PSLVERR                    (pslverr),
        .GREEN_PREDISCHARGE_LEVEL   (gpd),
        .BLUE_PREDISCHARGE_LEVEL    (bpd),
        .RED_DECOUPLING_LEVEL       (rdc),
        .GREEN_DECOUPLING_LEVEL     (gdc),
        .BLUE_DECOUPLING_LEVEL      (bdc),
        .RED_LOWGRAY_COMPENSATION   (rlg),
        .GREEN_LOWGRAY_COMPENSATION (glg),
        .BLUE_LOWGRAY_COMPENSATION  (blg),
        .RED_GROUP_NOISE_SELECT     (rns),
        .GREEN_GROUP_NOISE_SELECT   (gns),
        .BLUE_GROUP_NOISE_SELECT    (bns),
        .SUBPERIOD_CAP_ENABLE       (subp),
        .RED_COLOUR_GAIN            (rcg),
        .GREEN_COLOUR_GAIN          (gcg),
        .BLUE_COLOUR_GAIN           (bcg),
        .GLOBAL_BRIGHTNESS          (gbr),
        .SHORT_REMOVAL_LEVEL        (srm),
        .RED_SHORT_THRESHOLD        (rth),
        .GREEN_SHORT_THRESHOLD      (gth),
        .BLUE_SHORT_THRESHOLD       (bth)
    );

    // ----------------------------------------------------------------
    // bus tasks
    // ----------------------------------------------------------------
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
        end
        while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [1:0] idx, input logic [31:0] d, input logic [3:0] s);
        logic [47:0] m;
        logic [47:0] v;
        m = idx[0] ? {{8{s[1]}}, {8{s[0]}}, 32'h0000_0000}
                   : {16'h0000, {8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        v = idx[0] ? {d[15:0], 32'h0000_0000} : {16'h0000, d};
        apb(1'b1, {8'h00, idx, 2'b00}, d, s);
        `CHK(err, 1'b0)
        if (idx[1])
            e1 = (e1 & ~(m & RW1)) | (v & m & RW1);
        else
            e0 = (e0 & ~(m & RW0)) | (v & m & RW0);
    endtask

    task automatic fields;
        @(negedge ref_clk);
        `CHK(gpd, e0[7:4])
        `CHK(bpd, e0[11:8])
        `CHK({bdc, gdc, rdc}, e0[23:12])
        `CHK({blg, glg, rlg}, e0[35:24])
        `CHK({bns, gns, rns}, e0[41:39])
        `CHK(subp, e0[42])
        `CHK({bcg, gcg, rcg}, e1[31:8])
        `CHK(gbr, e1[34:32])
        `CHK(srm, e1[38:35])
        `CHK(rth, e1[41:39])
        `CHK({bth, gth}, e1[47:42])
    endtask

    task automatic chk_all;
        logic [47:0] w;
        for (int i = 0; i < 4; i++)
        begin
            w = i[1] ? e1 : e0;
            apb(1'b0, {8'h00, i[1:0], 2'b00}, 32'h0000_0000, 4'h0);
            `CHK(rd, i[0] ? {16'h0000, w[47:32]} : w[31:0])
            `CHK(err, 1'b0)
        end
        fields();
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial
    begin
        repeat (50000) @(posedge ref_clk);
        bad_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_sim();
    end

    initial
    begin
        e0 = RST0;
        e1 = RST1;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        chk_all();
        $display("test reset values done");
        for (int i = 0; i < 4; i++)
            wr(i[1:0], 32'hFFFF_FFFF, 4'hF);
        chk_all();
        $display("test all ones done");
        for (int c = 0; c < 16; c++)
        begin
            for (int i = 0; i < 4; i++)
                wr(i[1:0], {8{c[3:0]}}, 4'hF);
            chk_all();
        end
        $display("test code sweep done");
        for (int i = 0; i < 4; i++)
        begin
            wr(i[1:0], 32'h0000_0000, 4'b0101);
            wr(i[1:0], 32'hA5C3_5AE7, 4'b1010);
        end
        chk_all();
        $display("test byte lanes done");
        foreach (paddr_tab[k])
        begin
            apb(1'b1, paddr_tab[k], 32'h0000_0000, 4'hF);
            `CHK(err, 1'b1)
            apb(1'b0, paddr_tab[k], 32'h0000_0000, 4'h0);
            `CHK({err, rd}, {1'b1, 32'h0000_0000})
        end
        chk_all();
        $display("test unmapped done");
        @(posedge ref_clk);
        rst <= 1'b1;
        e0 = RST0;
        e1 = RST1;
        fields();
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        chk_all();
        $display("test mid-run reset done");
        end_sim();
    end

endmodule

`default_nettype wire
